/* hw/ccp_pkg.sv */
// Constants shared by the clock and power controller
package ccp_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
   localparam logic [7:0] OFS_CLOCK_STATE = 8'h04;
   localparam logic [7:0] OFS_PLL_CONTROL = 8'h08;
   localparam logic [7:0] OFS_CLOCK_SELECT_ZERO = 8'h0c;
   localparam logic [7:0] OFS_TICK_CONTROL = 8'h10;
   localparam logic [7:0] OFS_FREQ_DIVIDER = 8'h14;
   localparam logic [7:0] OFS_INT_STATUS = 8'h18;
   localparam logic [7:0] OFS_INT_CLEAR = 8'h1c;
   localparam logic [7:0] OFS_INT_ENABLE = 8'h20;
   // ==========================================================
   // Field positions
   localparam int BIT_CRYSTAL_ENABLE = 0;
   localparam int BIT_FAST_RC_ENABLE = 2;
   localparam int BIT_SLOW_RC_ENABLE = 3;
   localparam int BIT_POWER_DOWN_ENABLE = 7;
   localparam int BIT_POWER_DOWN_WAIT_CORE = 8;
   localparam int BIT_CRYSTAL_STABLE = 0;
   localparam int BIT_PLL_STABLE = 2;
   localparam int BIT_SLOW_RC_STABLE = 3;
   localparam int BIT_FAST_RC_STABLE = 4;
   localparam int BIT_PLL_POWER_OFF = 16;
   localparam int BIT_PLL_REFERENCE_SELECT = 19;
   localparam int BIT_TICK_USE_CORE = 2;
   localparam int BIT_DIVIDER_ENABLE = 4;
   localparam int SYS_SEL_LSB = 0;
   localparam int TICK_SEL_LSB = 3;
   localparam int SEL_W = 3;
   localparam int TAP_W = 4;
   // ==========================================================
   // Source indices and interrupt events
   localparam int NUM_SRC = 4;
   localparam int SRC_CRYSTAL = 0;
   localparam int SRC_PLL = 1;
   localparam int SRC_FAST_RC = 2;
   localparam int SRC_SLOW_RC = 3;
   localparam int NUM_OSC_PIN = 3;
   localparam int NUM_EVT = 3;
   localparam int EVT_WAKE = 0;
   localparam int EVT_STABLE = 1;
   localparam int EVT_SLEEP = 2;
   localparam int NUM_PERIPH = 3;
   // ==========================================================
   // Stable counts in source cycles
   localparam int CNT_W = 13;
   localparam int STABLE_CRYSTAL = 4096;
   localparam int STABLE_PLL = 6144;
   localparam int STABLE_FAST_RC = 256;
   localparam int STABLE_SLOW_RC = 1;
   // ==========================================================
   // Reset values and select codes
   localparam logic [31:0] RST_POWER_CONTROL = 32'h0000_0004;
   localparam logic [31:0] RST_PLL_CONTROL = 32'h0001_0000;
   localparam logic [2:0] RST_SYS_SEL = 3'h2;
   localparam logic [2:0] SYS_CRYSTAL = 3'h0;
   localparam logic [2:0] SYS_PLL = 3'h1;
   localparam logic [2:0] SYS_FAST_RC = 3'h2;
   localparam logic [2:0] SYS_SLOW_RC = 3'h3;
   localparam logic [2:0] SYS_FAST_RC_ALT = 3'h4;
   localparam logic [2:0] TICK_CRYSTAL = 3'h0;
   localparam logic [2:0] TICK_SLOW_RC = 3'h1;
   localparam logic [2:0] TICK_CRYSTAL_ALT = 3'h2;
   localparam logic [2:0] TICK_FAST_RC = 3'h3;
endpackage

/* hw/ccp_clock_power.sv */
// Clock sources, stability tracking, power-down, clock selects and divider
//
// Contract
// - Power-down is entered on a wait-for-interrupt pulse only when both enable bits are 1.
// - Power-down lasts until a wake-up source fires, then it is left.
// - In power-down the crystal and the fast RC oscillator are switched off.
// - Four sources exist, and the PLL reference is the crystal or the fast RC.
// - Enabling a source starts its stable counter and its flag sets at the final count.
// - Stable counts are 4096 crystal, 6144 PLL reference, 256 fast RC and 1 slow RC cycles.
// - The reference select picks crystal at 0 and fast RC at 1, also for the PLL counter.
// - A source may be used as system or tick clock only while its flag is 1; the code only gates the switch and keeps it after the flag drops.
// - Clearing an enable or setting PLL power-off clears that stable flag at once.
// - Power-down entry clears crystal, fast RC and PLL flags; enabled ones recount after wake.
// - The system clock comes from five sources by a 3-bit field.
// - The tick uses the core clock or an external one picked from four by a 3-bit field.
// - In power-down the slow RC runs and peripherals on it keep their clocks.
// - The divider is 16 chained halving stages with a 16-to-1 tap selector.
// - Output frequency is input frequency over two to the power of tap plus one.
// - Enable starts the chain; disable lets it run until the output is low, then holds low.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module ccp_clock_power #(
   parameter int CRYSTAL_COUNT = ccp_pkg::STABLE_CRYSTAL,
   parameter int PLL_COUNT = ccp_pkg::STABLE_PLL,
   parameter int FAST_RC_COUNT = ccp_pkg::STABLE_FAST_RC,
   parameter int SLOW_RC_COUNT = ccp_pkg::STABLE_SLOW_RC,
   parameter int DIV_STAGES = 16
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Core and wake-up
   input wire logic wait_for_interrupt_instr,
   input wire logic wake_event,
   // Raw oscillator clocks: crystal, fast RC, slow RC
   input wire logic [ccp_pkg::NUM_OSC_PIN-1:0] osc_clk_in,
   // Peripherals on slow RC: watchdog, timer, pwm
   input wire logic [ccp_pkg::NUM_PERIPH-1:0] periph_uses_slow_rc,
   // Oscillator controls and clock steering
   output logic [ccp_pkg::NUM_SRC-1:0] source_on,
   output logic [ccp_pkg::NUM_SRC-1:0] source_stable,
   output logic pll_reference_select,
   output logic [ccp_pkg::SEL_W-1:0] system_clock_select,
   output logic [ccp_pkg::SEL_W-1:0] tick_ext_source_select,
   output logic tick_use_core,
   output logic [ccp_pkg::NUM_PERIPH-1:0] periph_clock_on,
   output logic power_down,
   output logic divided_clock_pin,
   output logic irq
);
   // ==========================================================
   // Registers
   logic [31:0] power_control_reg_ff;
   logic [31:0] pll_control_reg_ff;
   logic [2*ccp_pkg::SEL_W-1:0] clock_select_reg_zero_ff;
   logic tick_control_ff;
   logic [ccp_pkg::TAP_W:0] freq_divider_reg_ff;
   logic [ccp_pkg::NUM_EVT-1:0] int_status_ff;
   logic [ccp_pkg::NUM_EVT-1:0] int_enable_ff;
   logic [31:0] rdata_ff;
   logic power_down_ff;
   logic [ccp_pkg::NUM_SRC-1:0] on_ff;
   logic [ccp_pkg::NUM_SRC-1:0] stable_ff;
   logic [ccp_pkg::SEL_W-1:0] sys_sel_ff;
   logic [ccp_pkg::SEL_W-1:0] tick_sel_ff;
   logic tick_core_ff;
   logic pll_ref_ff;
   logic [ccp_pkg::NUM_PERIPH-1:0] periph_on_ff;
   logic [DIV_STAGES-1:0] chain_ff;
   logic div_out_ff;
   logic irq_ff;
   logic nxt_power_down;
   logic [ccp_pkg::NUM_SRC-1:0] nxt_on;
   logic [ccp_pkg::NUM_OSC_PIN-1:0] osc_edge;
   logic [ccp_pkg::NUM_SRC-1:0] count_edge;
   logic [ccp_pkg::NUM_SRC-1:0] nxt_stable;
   logic wr_power, wr_pll, wr_sel, wr_tick, wr_div, wr_clr, wr_ien;
   logic sys_ok, tick_ok;
   logic [ccp_pkg::SEL_W-1:0] sys_req, tick_req;
   logic sleep_entry;
   localparam int TARGET [ccp_pkg::NUM_SRC] = '{CRYSTAL_COUNT, PLL_COUNT, FAST_RC_COUNT,
      SLOW_RC_COUNT};

   assign wr_power = reg_write && reg_addr == ccp_pkg::OFS_POWER_CONTROL;
   assign wr_pll = reg_write && reg_addr == ccp_pkg::OFS_PLL_CONTROL;
   assign wr_sel = reg_write && reg_addr == ccp_pkg::OFS_CLOCK_SELECT_ZERO;
   assign wr_tick = reg_write && reg_addr == ccp_pkg::OFS_TICK_CONTROL;
   assign wr_div = reg_write && reg_addr == ccp_pkg::OFS_FREQ_DIVIDER;
   assign wr_clr = reg_write && reg_addr == ccp_pkg::OFS_INT_CLEAR;
   assign wr_ien = reg_write && reg_addr == ccp_pkg::OFS_INT_ENABLE;

   // ==========================================================
   // Software registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         power_control_reg_ff <= ccp_pkg::RST_POWER_CONTROL;
         pll_control_reg_ff <= ccp_pkg::RST_PLL_CONTROL;
         clock_select_reg_zero_ff <= '0;
         tick_control_ff <= 1'b0;
         freq_divider_reg_ff <= '0;
         int_enable_ff <= '0;
      end else begin
         if (wr_power) begin
            power_control_reg_ff <= reg_wdata;
         end
         if (wr_pll) begin
            pll_control_reg_ff <= reg_wdata;
         end
         if (wr_sel) begin
            clock_select_reg_zero_ff <= reg_wdata[2*ccp_pkg::SEL_W-1:0];
         end
         if (wr_tick) begin
            tick_control_ff <= reg_wdata[ccp_pkg::BIT_TICK_USE_CORE];
         end
         if (wr_div) begin
            freq_divider_reg_ff <= reg_wdata[ccp_pkg::TAP_W:0];
         end
         if (wr_ien) begin
            int_enable_ff <= reg_wdata[ccp_pkg::NUM_EVT-1:0];
         end
      end
   end

   // ==========================================================
   // Power-down
   // entry gate
   assign sleep_entry = !power_down_ff && wait_for_interrupt_instr
      && power_control_reg_ff[ccp_pkg::BIT_POWER_DOWN_ENABLE]
      && power_control_reg_ff[ccp_pkg::BIT_POWER_DOWN_WAIT_CORE];
   assign nxt_power_down = power_down_ff ? !wake_event : sleep_entry;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         power_down_ff <= 1'b0;
      end else begin
         power_down_ff <= nxt_power_down;
      end
   end

   always_comb begin
      nxt_on[ccp_pkg::SRC_CRYSTAL] = power_control_reg_ff[ccp_pkg::BIT_CRYSTAL_ENABLE]
         && !nxt_power_down;
      nxt_on[ccp_pkg::SRC_FAST_RC] = power_control_reg_ff[ccp_pkg::BIT_FAST_RC_ENABLE]
         && !nxt_power_down;
      nxt_on[ccp_pkg::SRC_PLL] = !pll_control_reg_ff[ccp_pkg::BIT_PLL_POWER_OFF]
         && !nxt_power_down;
      // slow RC keeps running in power-down
      nxt_on[ccp_pkg::SRC_SLOW_RC] = power_control_reg_ff[ccp_pkg::BIT_SLOW_RC_ENABLE];
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         on_ff <= '0;
         periph_on_ff <= '0;
         pll_ref_ff <= 1'b0;
      end else begin
         on_ff <= nxt_on;
         // peripheral clocks survive only on slow RC
         periph_on_ff <= {ccp_pkg::NUM_PERIPH{!nxt_power_down}} | periph_uses_slow_rc;
         pll_ref_ff <= pll_control_reg_ff[ccp_pkg::BIT_PLL_REFERENCE_SELECT];
      end
   end

   // ==========================================================
   // Oscillator edge detection
   genvar gi;
   generate
      for (gi = 0; gi < ccp_pkg::NUM_OSC_PIN; gi++) begin : g_sync
         logic s1_ff, s2_ff, s3_ff, level_ff;
         // three-stage synchroniser, change accepted when stages agree
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
               level_ff <= 1'b0;
            end else begin
               s1_ff <= osc_clk_in[gi];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (s2_ff == s3_ff) begin
                  level_ff <= s3_ff;
               end
            end
         end
         assign osc_edge[gi] = s2_ff && s3_ff && !level_ff;
      end
   endgenerate

   // four sources; reference select steers the PLL counter
   assign count_edge[ccp_pkg::SRC_CRYSTAL] = osc_edge[0];
   assign count_edge[ccp_pkg::SRC_PLL] = pll_ref_ff ? osc_edge[1] : osc_edge[0];
   assign count_edge[ccp_pkg::SRC_FAST_RC] = osc_edge[1];
   assign count_edge[ccp_pkg::SRC_SLOW_RC] = osc_edge[2];

   // ==========================================================
   // Stable counters
   generate
      for (gi = 0; gi < ccp_pkg::NUM_SRC; gi++) begin : g_stable
         logic [ccp_pkg::CNT_W-1:0] cnt_ff;
         localparam logic [ccp_pkg::CNT_W-1:0] LIMIT = TARGET[gi][ccp_pkg::CNT_W-1:0];
         // count while enabled; per-source target; restart when off
         always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
               cnt_ff <= '0;
            end else if (!nxt_on[gi]) begin
               cnt_ff <= '0;
            end else if (count_edge[gi] && cnt_ff != LIMIT) begin
               cnt_ff <= cnt_ff + 1'b1;
            end
         end
         assign nxt_stable[gi] = nxt_on[gi] && (cnt_ff == LIMIT
            || (count_edge[gi] && cnt_ff == LIMIT - 1'b1));
      end
   endgenerate

   // flags drop as soon as a source is off
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         stable_ff <= '0;
      end else begin
         stable_ff <= nxt_stable;
      end
   end

   // ==========================================================
   // Clock selection
   always_comb begin
      sys_req = clock_select_reg_zero_ff[ccp_pkg::SYS_SEL_LSB +: ccp_pkg::SEL_W];
      tick_req = clock_select_reg_zero_ff[ccp_pkg::TICK_SEL_LSB +: ccp_pkg::SEL_W];
      case (sys_req)
         ccp_pkg::SYS_CRYSTAL: sys_ok = stable_ff[ccp_pkg::SRC_CRYSTAL];
         ccp_pkg::SYS_PLL: sys_ok = stable_ff[ccp_pkg::SRC_PLL];
         ccp_pkg::SYS_FAST_RC: sys_ok = stable_ff[ccp_pkg::SRC_FAST_RC];
         ccp_pkg::SYS_SLOW_RC: sys_ok = stable_ff[ccp_pkg::SRC_SLOW_RC];
         ccp_pkg::SYS_FAST_RC_ALT: sys_ok = stable_ff[ccp_pkg::SRC_FAST_RC];
         default: sys_ok = 1'b0;
      endcase
      case (tick_req)
         ccp_pkg::TICK_CRYSTAL: tick_ok = stable_ff[ccp_pkg::SRC_CRYSTAL];
         ccp_pkg::TICK_SLOW_RC: tick_ok = stable_ff[ccp_pkg::SRC_SLOW_RC];
         ccp_pkg::TICK_CRYSTAL_ALT: tick_ok = stable_ff[ccp_pkg::SRC_CRYSTAL];
         ccp_pkg::TICK_FAST_RC: tick_ok = stable_ff[ccp_pkg::SRC_FAST_RC];
         default: tick_ok = 1'b0;
      endcase
   end

   // switch only onto a stable source; otherwise keep the old one
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sys_sel_ff <= ccp_pkg::RST_SYS_SEL;
         tick_sel_ff <= '0;
         tick_core_ff <= 1'b0;
      end else begin
         if (sys_ok) begin
            sys_sel_ff <= sys_req;
         end
         if (tick_ok) begin
            tick_sel_ff <= tick_req;
         end
         tick_core_ff <= tick_control_ff;
      end
   end

   // ==========================================================
   // Frequency divider
   // chained halving stages; tap N gives clock over 2^(N+1)
   // disabled chain runs on until the tap is low, then parks cleared
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         chain_ff <= '0;
         div_out_ff <= 1'b0;
      end else if (freq_divider_reg_ff[ccp_pkg::BIT_DIVIDER_ENABLE] || div_out_ff) begin
         chain_ff <= chain_ff + 1'b1;
         // Tap is registered once more so the pin comes straight from a flop
         div_out_ff <= chain_ff[freq_divider_reg_ff[ccp_pkg::TAP_W-1:0]];
      end else begin
         chain_ff <= '0;
         div_out_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Interrupts and read data
   // Set wins over a same-cycle clear so no event is lost
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         int_status_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         int_status_ff <= (int_status_ff
            & ~(wr_clr ? reg_wdata[ccp_pkg::NUM_EVT-1:0] : '0))
            | {sleep_entry, |(nxt_stable & ~stable_ff), power_down_ff && wake_event};
         irq_ff <= |(int_status_ff & int_enable_ff);
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata_ff <= '0;
      end else begin
         rdata_ff <= '0;
         if (reg_read) begin
            case (reg_addr)
               ccp_pkg::OFS_POWER_CONTROL: rdata_ff <= power_control_reg_ff;
               // flags seen by software come from synchronised counts
               ccp_pkg::OFS_CLOCK_STATE: begin
                  rdata_ff[ccp_pkg::BIT_CRYSTAL_STABLE] <= stable_ff[ccp_pkg::SRC_CRYSTAL];
                  rdata_ff[ccp_pkg::BIT_PLL_STABLE] <= stable_ff[ccp_pkg::SRC_PLL];
                  rdata_ff[ccp_pkg::BIT_SLOW_RC_STABLE] <= stable_ff[ccp_pkg::SRC_SLOW_RC];
                  rdata_ff[ccp_pkg::BIT_FAST_RC_STABLE] <= stable_ff[ccp_pkg::SRC_FAST_RC];
               end
               ccp_pkg::OFS_PLL_CONTROL: rdata_ff <= pll_control_reg_ff;
               ccp_pkg::OFS_CLOCK_SELECT_ZERO: rdata_ff <= 32'(clock_select_reg_zero_ff);
               ccp_pkg::OFS_TICK_CONTROL: rdata_ff[ccp_pkg::BIT_TICK_USE_CORE] <= tick_control_ff;
               ccp_pkg::OFS_FREQ_DIVIDER: rdata_ff <= 32'(freq_divider_reg_ff);
               ccp_pkg::OFS_INT_STATUS: rdata_ff <= 32'(int_status_ff);
               ccp_pkg::OFS_INT_ENABLE: rdata_ff <= 32'(int_enable_ff);
               default: rdata_ff <= '0;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_ff;
   assign source_on = on_ff;
   assign source_stable = stable_ff;
   assign pll_reference_select = pll_ref_ff;
   assign system_clock_select = sys_sel_ff;
   assign tick_ext_source_select = tick_sel_ff;
   assign tick_use_core = tick_core_ff;
   assign periph_clock_on = periph_on_ff;
   assign power_down = power_down_ff;
   assign divided_clock_pin = div_out_ff;
   assign irq = irq_ff;

   // ==========================================================
   // Assertions
   sleep_entry_a: assert property (@(posedge clock) disable iff (!reset_n)
      sleep_entry |=> power_down_ff)
      else $error("power-down not entered");
   sleep_cause_a: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(power_down_ff) |-> $past(wait_for_interrupt_instr)
      && $past(power_control_reg_ff[ccp_pkg::BIT_POWER_DOWN_ENABLE])
      && $past(power_control_reg_ff[ccp_pkg::BIT_POWER_DOWN_WAIT_CORE]))
      else $error("power-down without cause");
   wake_exit_a: assert property (@(posedge clock) disable iff (!reset_n)
      power_down_ff && wake_event |=> !power_down_ff)
      else $error("wake did not leave power-down");
   osc_off_a: assert property (@(posedge clock) disable iff (!reset_n)
      power_down_ff |-> !on_ff[ccp_pkg::SRC_CRYSTAL] && !on_ff[ccp_pkg::SRC_FAST_RC])
      else $error("oscillator on in power-down");
   sleep_flags_a: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(power_down_ff) |-> !stable_ff[ccp_pkg::SRC_CRYSTAL]
      && !stable_ff[ccp_pkg::SRC_FAST_RC] && !stable_ff[ccp_pkg::SRC_PLL])
      else $error("flag kept over power-down");
   disable_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      $fell(power_control_reg_ff[ccp_pkg::BIT_CRYSTAL_ENABLE])
      |=> !stable_ff[ccp_pkg::SRC_CRYSTAL])
      else $error("crystal flag not cleared");
   slow_stable_a: assert property (@(posedge clock) disable iff (!reset_n)
      $rose(stable_ff[ccp_pkg::SRC_SLOW_RC]) |-> $past(osc_edge[2]))
      else $error("slow RC flag set without an edge");
   sys_switch_a: assert property (@(posedge clock) disable iff (!reset_n)
      $changed(sys_sel_ff) |-> $past(sys_ok))
      else $error("system clock switched to unstable source");
   periph_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
      power_down_ff |-> periph_on_ff == $past(periph_uses_slow_rc))
      else $error("peripheral clock wrong in power-down");
   div_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      !freq_divider_reg_ff[ccp_pkg::BIT_DIVIDER_ENABLE] && !div_out_ff |=> !div_out_ff)
      else $error("divider output left low state");
   div_fast_a: assert property (@(posedge clock) disable iff (!reset_n)
      (freq_divider_reg_ff == 5'h10)[*4] |-> div_out_ff != $past(div_out_ff))
      else $error("tap zero did not halve the clock");
endmodule

/* bench/ccp_osc_model.sv */
// Oscillator model on the far side of the clock controller
`timescale 1ns/1ns
module ccp_osc_model #(
   parameter int HALF = 5
) (
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Oscillator enables
   input wire logic [3:0] source_on,
   // Raw oscillator clocks
   output logic [2:0] osc_clk_in
);
   // ==========
   // Slow oscillators
   int cnt_ff;
   logic [2:0] osc_ff;
   assign osc_clk_in = osc_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 0;
         osc_ff <= 3'h0;
      end else begin
         cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
         // Disabled oscillator stands still low
         if (cnt_ff == HALF - 1) begin
            osc_ff <= ~osc_ff & {source_on[3], source_on[2], source_on[0]};
         end else begin
            osc_ff <= osc_ff & {source_on[3], source_on[2], source_on[0]};
         end
      end
   end
endmodule

/* bench/test_chip_clock_power_controller.sv */
// Self-checking bench for the clock and power controller
`timescale 1ns/1ns
module test_chip_clock_power_controller;
   // ==========
   // Signals
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic sleep_req = 1'b0;
   logic wake = 1'b0;
   logic [2:0] uses = 3'h5;
   logic [31:0] reg_rdata;
   logic [2:0] osc, periph_on, sys_sel, tick_sel;
   logic [3:0] src_on, stable;
   logic pll_ref, tick_core, asleep, div_pin, irq;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   int k;
   always #10 clock = ~clock;
   ccp_clock_power #(.CRYSTAL_COUNT(4), .PLL_COUNT(6), .FAST_RC_COUNT(2), .SLOW_RC_COUNT(1)) dut (
      .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .wait_for_interrupt_instr(sleep_req), .wake_event(wake), .osc_clk_in(osc),
      .periph_uses_slow_rc(uses), .source_on(src_on), .source_stable(stable),
      .pll_reference_select(pll_ref), .system_clock_select(sys_sel),
      .tick_ext_source_select(tick_sel), .tick_use_core(tick_core),
      .periph_clock_on(periph_on), .power_down(asleep), .divided_clock_pin(div_pin), .irq(irq));
   ccp_osc_model osc_model (.clock(clock), .reset_n(reset_n), .source_on(src_on),
      .osc_clk_in(osc));
   // ==========
   // Tasks
   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] e, string w);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(w, e, reg_rdata & m);
   endtask
   task automatic wt(int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic await(int b);
      for (n = 0; n < 400 && stable[b] !== 1'b1; n++) @(posedge clock);
      #1 chk("stable", 1, stable[b]);
   endtask
   task automatic pulse_sleep();
      @(posedge clock);
      sleep_req <= 1'b1;
      @(posedge clock);
      sleep_req <= 1'b0;
      #1;
   endtask
   // Edge-to-edge period of the divided pin
   task automatic rise(output int p);
      p = 0;
      // Look after the edge so the pin has settled
      do begin @(posedge clock); #1 p++; end while (div_pin !== 1'b0 && p < 99);
      do begin @(posedge clock); #1 p++; end while (div_pin !== 1'b1 && p < 99);
   endtask
   task automatic final_report();
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Ceiling well above the expected run length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   // ==========
   // Scenarios
   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      rd(8'h00, '1, 32'h4, "power_ctrl");
      rd(8'h08, '1, 32'h10000, "pll_ctrl");
      wr(8'h40, 32'hffff);
      rd(8'h40, '1, 32'h0, "unmapped");
      await(2);
      rd(8'h04, 32'h10, 32'h10, "state_fast");
      wr(8'h0c, 32'h0);
      wt(5);
      chk("sys_sel_gated", 2, sys_sel);
      wr(8'h00, 32'hd);
      await(0);
      chk("crystal_late", 1, n >= 30);
      wt(3);
      chk("sys_sel", 0, sys_sel);
      chk("tick_sel", 0, tick_sel);
      wr(8'h0c, 32'h18);
      wr(8'h10, 32'h4);
      wt(3);
      chk("tick_fast", 3, tick_sel);
      chk("tick_core", 1, tick_core);
      chk("sys_kept", 0, sys_sel);
      wr(8'h08, 32'h80000);
      await(1);
      chk("pll_ref", 1, pll_ref);
      wr(8'h08, 32'h10000);
      wt(3);
      chk("pll_off", 0, stable[1]);
      wr(8'h00, 32'hc);
      wt(3);
      chk("xtal_off", 0, stable[0]);
      wr(8'h00, 32'h8c);
      pulse_sleep();
      chk("sleep_refused", 0, asleep);
      wr(8'h00, 32'h18c);
      wr(8'h20, 32'h4);
      wt(2);
      chk("irq_idle", 0, irq);
      pulse_sleep();
      chk("asleep", 1, asleep);
      chk("osc_off", 0, src_on & 4'h7);
      chk("flags_off", 0, stable & 4'h7);
      chk("slow_rc", 1, stable[3]);
      chk("periph", 32'h5, periph_on);
      wt(2);
      chk("irq", 1, irq);
      wt(60);
      chk("sleep_stays", 1, asleep);
      @(posedge clock);
      wake <= 1'b1;
      @(posedge clock);
      wake <= 1'b0;
      wt(1);
      chk("woken", 0, asleep);
      await(2);
      rd(8'h18, 32'h5, 32'h5, "status");
      wr(8'h1c, 32'h5);
      wt(2);
      chk("irq_clr", 0, irq);
      rd(8'h1c, '1, 32'h0, "clear_reads");
      for (int t = 0; t < 3; t++) begin
         wr(8'h14, 32'h10 | t);
         rise(k);
         rise(k);
         chk("div_period", 2 << t, k);
      end
      wr(8'h14, 32'h0);
      wt(20);
      k = 0;
      repeat (20) begin @(posedge clock); k += div_pin; end
      chk("div_held_low", 0, k);
      final_report();
   end
endmodule
